// >>> common/adm_ctrl_regs.svh
// register offsets, field positions and reset values of the codec control block
`ifndef ADM_CTRL_REGS_SVH
`define ADM_CTRL_REGS_SVH
`define CLK_SRC_ADDR      8'h73
`define IRQ_CTRL_ADDR     8'h81
`define DEC_SETUP_ADDR    8'hd0
`define PCM_OUT_ADDR      8'hd6
`define PCM_IN_ADDR       8'hd7
`define DELTA_FEED_ADDR   8'hd8
`define DELTA_RESULT_ADDR 8'hda
`define STATUS_ADDR       8'he1
`define CLK_SRC_RST       16'h0000
`define IRQ_CTRL_RST      8'h00
`define DEC_SETUP_RST     16'h0000
`define ENC_SEL_HI        5
`define ENC_SEL_LO        4
`define FILT_BYPASS_BIT   3
`define SLICER_PWR_HI     2
`define SLICER_PWR_LO     1
`define FILT_NARROW_BIT   0
`define ENC_RUN_BIT       7
`define ENC_IE_VOICE_BIT  6
`define ENC_IE_PCM_BIT    5
`define ENC_IE_ADM_BIT    4
`define DEC_RUN_BIT       3
`define DEC_IE_VOICE_BIT  2
`define DEC_IE_PCM_BIT    1
`define DEC_IE_ADM_BIT    0
`define RATE4_BIT         15
`define PCM_SEL_HI        14
`define PCM_SEL_LO        13
`define ADM_SEL_HI        12
`define ADM_SEL_LO        11
`define OUT_SEL_HI        10
`define OUT_SEL_LO        9
`define ADDR_BITS         5'd8
`define BYTE_BITS         5'd8
`define WORD_BITS         5'd16
`endif

// >>> common/adm_ctrl_pkg.sv
// types shared by the codec control block
package adm_ctrl_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_addr = 2'b01,
    st_data = 2'b10,
    st_done = 2'b11
  } ser_state_t;
endpackage

// >>> hw/adm_codec_ctrl.sv
// codec clock, slicer, enable and decoder routing control behind the serial host port
`timescale 1ns/1ps
`default_nettype none
`include "adm_ctrl_regs.svh"

module adm_codec_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        host_sclk,
  input  wire logic        host_cs_n,
  input  wire logic        host_cmd,
  output logic             host_reply,
  input  wire logic        rx_data_pin,
  input  wire logic        filt_data,
  input  wire logic        ext_tx_clk_pin,
  input  wire logic        int_enc_clk,
  input  wire logic        dec_clk,
  input  wire logic        enc_voice_chg,
  input  wire logic        enc_pcm_tick,
  input  wire logic        enc_adm_tick,
  input  wire logic        dec_voice_chg,
  input  wire logic        dec_pcm_tick,
  input  wire logic        dec_adm_tick,
  input  wire logic [15:0] burst_pcm,
  input  wire logic        feedback_bit,
  input  wire logic [15:0] est_word,
  input  wire logic [15:0] interp_word,
  input  wire logic [15:0] decim_word,
  input  wire logic        decim_valid,
  input  wire logic        transc_bit,
  input  wire logic        transc_valid,
  output logic             enc_bit_clk,
  output logic             slicer_in,
  output logic [1:0]       slicer_pwr,
  output logic             filt_narrow,
  output logic             enc_run,
  output logic             dec_run,
  output logic             enc_irq,
  output logic             dec_irq,
  output logic             rate_factor4,
  output logic [1:0]       pcm_in_sel,
  output logic [15:0]      filt_src,
  output logic             adm_dec_bit,
  output logic [15:0]      dec_out
);
  import adm_ctrl_pkg::*;
  // two-stage synchronisers for pins; only stage two is read
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       sclk_d;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1  <= 5'h00;
      sync2  <= 5'h00;
      sclk_d <= 1'b0;
    end else begin
      sync1  <= {host_sclk, ~host_cs_n, host_cmd, rx_data_pin, ext_tx_clk_pin};
      sync2  <= sync1;
      sclk_d <= sync2[4];
    end
  end
  logic sclk_rise;
  logic cs_act;
  logic cmd_s;
  logic rx_s;
  logic txclk_s;
  assign sclk_rise = sync2[4] & ~sclk_d;
  assign cs_act    = sync2[3];
  assign cmd_s     = sync2[2];
  assign rx_s      = sync2[1];
  assign txclk_s   = sync2[0];
  // register file and serial host port state
  ser_state_t  state;
  ser_state_t  next_state;
  logic [4:0]  cnt, next_cnt;
  logic [15:0] sh, next_sh;
  logic [15:0] tx, next_tx;
  logic [7:0]  addr, next_addr;
  logic        next_host_reply;
  logic [15:0] clock_source_and_slicer_control, next_clk_ctrl;
  logic [7:0]  codec_irq_enable_control, next_irq_ctrl;
  logic [15:0] decoder_mode_setup, next_setup;
  logic [15:0] pcm_in_reg, next_pcm_in;
  logic [15:0] decoder_delta_feed_reg, next_feed;
  logic [15:0] pcm_out_reg, next_pcm_out;
  logic [15:0] decoder_delta_result_reg, next_result;
  logic [4:0]  len;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  assign len     = (addr == `IRQ_CTRL_ADDR) ? `BYTE_BITS : `WORD_BITS;
  assign wr_word = {sh[14:0], cmd_s};
  // read multiplexer keyed by the address byte as it completes, so it never loops
  // back through the frame logic; byte registers go out in the upper lane
  always_comb begin
    rd_word = 16'h0000;
    unique case (wr_word[7:0])
      `CLK_SRC_ADDR:      rd_word = clock_source_and_slicer_control;
      `IRQ_CTRL_ADDR:     rd_word = {codec_irq_enable_control, 8'h00};
      `DEC_SETUP_ADDR:    rd_word = decoder_mode_setup;
      `PCM_OUT_ADDR:      rd_word = pcm_out_reg;
      `DELTA_RESULT_ADDR: rd_word = decoder_delta_result_reg;
      `STATUS_ADDR:       rd_word = {10'h000, enc_run, dec_run, rx_s, txclk_s, slicer_pwr};
      default:            rd_word = 16'h0000;
    endcase
  end
  // serial frame: address byte, then 8 or 16 data bits, msb first
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_sh         = sh;
    next_tx         = tx;
    next_addr       = addr;
    next_clk_ctrl   = clock_source_and_slicer_control;
    next_irq_ctrl   = codec_irq_enable_control;
    next_setup      = decoder_mode_setup;
    next_pcm_in     = pcm_in_reg;
    next_feed       = decoder_delta_feed_reg;
    next_pcm_out    = pcm_out_reg;
    next_result     = decoder_delta_result_reg;
    // decimated words and transcoded bits land in the read-back registers
    if (decim_valid && !decoder_mode_setup[`PCM_SEL_HI]) begin
      next_pcm_out = decim_word;
    end
    if (transc_valid && decoder_mode_setup[`PCM_SEL_HI]) begin
      next_result = {decoder_delta_result_reg[14:0], transc_bit};
    end
    // host feed word rotates left one bit per decoder bit tick while it is the adm decoder input, msb wrapping into bit 0
    if (dec_adm_tick && decoder_mode_setup[`ADM_SEL_HI:`ADM_SEL_LO] == 2'b01) begin
      next_feed = {decoder_delta_feed_reg[14:0], decoder_delta_feed_reg[15]};
    end
    if (!cs_act) begin
      next_state = st_idle;
      next_cnt   = 5'd0;
    end else begin
      unique case (state)
        st_idle: begin
          next_state = st_addr;
          next_cnt   = 5'd0;
        end
        st_addr: begin
          if (sclk_rise) begin
            next_sh  = wr_word;
            next_cnt = cnt + 5'd1;
            if (cnt == `ADDR_BITS - 5'd1) begin
              next_addr  = wr_word[7:0];
              next_cnt   = 5'd0;
              next_state = st_data;
              next_tx    = rd_word;
            end
          end
        end
        st_data: begin
          if (sclk_rise) begin
            next_sh  = wr_word;
            next_tx  = {tx[14:0], 1'b0};
            next_cnt = cnt + 5'd1;
            if (cnt == len - 5'd1) begin
              next_state = st_done;
              unique case (addr)
                `CLK_SRC_ADDR:    next_clk_ctrl = wr_word;
                `IRQ_CTRL_ADDR:   next_irq_ctrl = wr_word[7:0];
                `DEC_SETUP_ADDR:  next_setup    = wr_word;
                `PCM_IN_ADDR:     next_pcm_in   = wr_word;
                `DELTA_FEED_ADDR: next_feed     = wr_word;
                default:          next_state    = st_done;
              endcase
            end
          end
        end
        st_done: next_state = st_done;
      endcase
    end
    next_host_reply = next_tx[15];
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state                           <= st_idle;
      cnt                             <= 5'd0;
      sh                              <= 16'h0000;
      tx                              <= 16'h0000;
      addr                            <= 8'h00;
      host_reply                      <= 1'b0;
      clock_source_and_slicer_control <= `CLK_SRC_RST;
      codec_irq_enable_control        <= `IRQ_CTRL_RST;
      decoder_mode_setup              <= `DEC_SETUP_RST;
      pcm_in_reg                      <= 16'h0000;
      decoder_delta_feed_reg          <= 16'h0000;
      pcm_out_reg                     <= 16'h0000;
      decoder_delta_result_reg        <= 16'h0000;
    end else begin
      state                           <= next_state;
      cnt                             <= next_cnt;
      sh                              <= next_sh;
      tx                              <= next_tx;
      addr                            <= next_addr;
      host_reply                      <= next_host_reply;
      clock_source_and_slicer_control <= next_clk_ctrl;
      codec_irq_enable_control        <= next_irq_ctrl;
      decoder_mode_setup              <= next_setup;
      pcm_in_reg                      <= next_pcm_in;
      decoder_delta_feed_reg          <= next_feed;
      pcm_out_reg                     <= next_pcm_out;
      decoder_delta_result_reg        <= next_result;
    end
  end
  // datapath steering computed from the control registers
  logic [7:0]  ic;
  logic [15:0] ds;
  logic [15:0] cc;
  logic        next_enc_clk, next_slicer, next_enc_irq, next_dec_irq, next_adm;
  logic [15:0] next_filt, next_out;
  assign ic = codec_irq_enable_control;
  assign ds = decoder_mode_setup;
  assign cc = clock_source_and_slicer_control;
  always_comb begin
    // encode clock source; bit 5 is a don't-care when bit 4 is clear
    if (!cc[`ENC_SEL_LO]) begin
      next_enc_clk = txclk_s;
    end else if (!cc[`ENC_SEL_HI]) begin
      next_enc_clk = int_enc_clk;
    end else begin
      next_enc_clk = dec_clk;
    end
    next_slicer  = cc[`FILT_BYPASS_BIT] ? rx_s : filt_data;
    next_enc_irq = ic[`ENC_RUN_BIT] & ((ic[`ENC_IE_VOICE_BIT] & enc_voice_chg)
                 | (ic[`ENC_IE_PCM_BIT] & enc_pcm_tick)
                 | (ic[`ENC_IE_ADM_BIT] & enc_adm_tick));
    next_dec_irq = ic[`DEC_RUN_BIT] & ((ic[`DEC_IE_VOICE_BIT] & dec_voice_chg)
                 | (ic[`DEC_IE_PCM_BIT] & dec_pcm_tick)
                 | (ic[`DEC_IE_ADM_BIT] & dec_adm_tick));
    // pcm filter input: estimator, burst word or host word
    if (!ds[`PCM_SEL_HI]) begin
      next_filt = est_word;
    end else if (!ds[`PCM_SEL_LO]) begin
      next_filt = burst_pcm;
    end else begin
      next_filt = pcm_in_reg;
    end
    // adm decoder input source
    if (ds[`ADM_SEL_HI]) begin
      next_adm = feedback_bit;
    end else if (ds[`ADM_SEL_LO]) begin
      next_adm = decoder_delta_feed_reg[15];
    end else begin
      next_adm = rx_s;
    end
    unique case (ds[`OUT_SEL_HI:`OUT_SEL_LO])
      2'b00: next_out = est_word;
      2'b01: next_out = est_word + interp_word;
      2'b10: next_out = next_filt;
      2'b11: next_out = interp_word;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enc_bit_clk  <= 1'b0;
      slicer_in    <= 1'b0;
      slicer_pwr   <= 2'b00;
      filt_narrow  <= 1'b0;
      enc_run      <= 1'b0;
      dec_run      <= 1'b0;
      enc_irq      <= 1'b0;
      dec_irq      <= 1'b0;
      rate_factor4 <= 1'b0;
      pcm_in_sel   <= 2'b00;
      filt_src     <= 16'h0000;
      adm_dec_bit  <= 1'b0;
      dec_out      <= 16'h0000;
    end else begin
      enc_bit_clk  <= next_enc_clk;
      slicer_in    <= next_slicer;
      slicer_pwr   <= cc[`SLICER_PWR_HI:`SLICER_PWR_LO];
      filt_narrow  <= cc[`FILT_NARROW_BIT];
      enc_run      <= ic[`ENC_RUN_BIT];
      dec_run      <= ic[`DEC_RUN_BIT];
      enc_irq      <= next_enc_irq;
      dec_irq      <= next_dec_irq;
      rate_factor4 <= ds[`RATE4_BIT];
      pcm_in_sel   <= ds[`PCM_SEL_HI:`PCM_SEL_LO];
      filt_src     <= next_filt;
      adm_dec_bit  <= next_adm;
      dec_out      <= next_out;
    end
  end
  chk_bypass_route: assert property (@(posedge ref_clk) disable iff (rst)
    cc[`FILT_BYPASS_BIT] |=> slicer_in == $past(rx_s))
    else $error("bypass did not route receive pin to slicer");
  chk_enc_held: assert property (@(posedge ref_clk) disable iff (rst)
    !ic[`ENC_RUN_BIT] |=> !enc_run && !enc_irq)
    else $error("disabled encoder ran or requested");
  chk_enc_voice: assert property (@(posedge ref_clk) disable iff (rst)
    ic[`ENC_RUN_BIT] && ic[`ENC_IE_VOICE_BIT] && enc_voice_chg |=> enc_irq)
    else $error("encoder voice change gave no request");
  chk_enc_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    ic[7:4] == 4'h8 |=> enc_run && !enc_irq)
    else $error("encoder without enables requested");
  chk_dec_held: assert property (@(posedge ref_clk) disable iff (rst)
    !ic[`DEC_RUN_BIT] |=> !dec_run && !dec_irq)
    else $error("disabled decoder ran or requested");
  chk_dec_adm: assert property (@(posedge ref_clk) disable iff (rst)
    ic[`DEC_RUN_BIT] && ic[`DEC_IE_ADM_BIT] && dec_adm_tick |=> dec_irq)
    else $error("decoder adm tick gave no request");
  chk_rate_factor: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 rate_factor4 == $past(ds[`RATE4_BIT]))
    else $error("rate factor not following setup");
  chk_adm_source: assert property (@(posedge ref_clk) disable iff (rst)
    ds[`ADM_SEL_HI] |=> adm_dec_bit == $past(feedback_bit))
    else $error("feedback source not selected");
  chk_out_interp: assert property (@(posedge ref_clk) disable iff (rst)
    ds[`OUT_SEL_HI:`OUT_SEL_LO] == 2'b11 |=> dec_out == $past(interp_word))
    else $error("interpolated output not selected");
  chk_enc_clock: assert property (@(posedge ref_clk) disable iff (rst)
    cc[`ENC_SEL_HI:`ENC_SEL_LO] == 2'b11 |=> enc_bit_clk == $past(dec_clk))
    else $error("encode clock not derived from decode clock");
endmodule
`default_nettype wire

// >>> verif/host_master.sv
// serial host master model driving the codec control port
`timescale 1ns/1ps
`default_nettype none
`include "adm_ctrl_regs.svh"
module host_master (
  input  wire logic ref_clk,
  output logic      host_sclk,
  output logic      host_cs_n,
  output logic      host_cmd,
  input  wire logic host_reply
);
  // idle: deselected, serial clock standing still
  initial begin
    host_sclk = 1'b0;
    host_cs_n = 1'b1;
    host_cmd  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one frame, msb first; every data bit is gathered from the reply line
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    int nd;
    nd = (a == `IRQ_CTRL_ADDR) ? 8 : 16;
    r = 16'h0000;
    wt(1);
    host_cs_n <= 1'b0;
    wt(4);
    for (int i = 0; i < 8 + nd; i++) begin
      host_cmd <= (i < 8) ? a[7 - i] : d[nd + 7 - i];
      wt(5);
      if (i >= 8) r = {r[14:0], host_reply};
      host_sclk <= 1'b1;
      wt(5);
      host_sclk <= 1'b0;
    end
    wt(5);
    host_cs_n <= 1'b1;
    host_cmd  <= ~host_cmd; // released line shows no stale level
    wt(5);
  endtask
endmodule
`default_nettype wire

// >>> verif/test_adm_codec_ctrl.sv
// self-checking bench for the codec control block
`timescale 1ns/1ps
`default_nettype none
`include "adm_ctrl_regs.svh"
module test_adm_codec_ctrl;
  logic ref_clk, rst, host_sclk, host_cs_n, host_cmd, host_reply, rx_data_pin, filt_data;
  logic ext_tx_clk_pin, int_enc_clk, dec_clk, feedback_bit, decim_valid, transc_bit, transc_valid;
  logic enc_voice_chg, enc_pcm_tick, enc_adm_tick, dec_voice_chg, dec_pcm_tick, dec_adm_tick;
  logic enc_bit_clk, slicer_in, filt_narrow, enc_run, dec_run, enc_irq, dec_irq;
  logic rate_factor4, adm_dec_bit, b;
  logic [15:0] burst_pcm, est_word, interp_word, decim_word, filt_src, dec_out;
  logic [15:0] rd, cv, sv, fv, pin, dw, tr, fs, ex;
  logic [7:0]  ic;
  logic [5:0]  ne, pe;
  logic [1:0]  slicer_pwr, pcm_in_sel, ps;
  int          n_fail, checks_done;

  adm_codec_ctrl dut (.ref_clk, .rst, .host_sclk, .host_cs_n, .host_cmd, .host_reply,
    .rx_data_pin, .filt_data, .ext_tx_clk_pin, .int_enc_clk, .dec_clk, .enc_voice_chg,
    .enc_pcm_tick, .enc_adm_tick, .dec_voice_chg, .dec_pcm_tick, .dec_adm_tick, .burst_pcm,
    .feedback_bit, .est_word, .interp_word, .decim_word, .decim_valid, .transc_bit,
    .transc_valid, .enc_bit_clk, .slicer_in, .slicer_pwr, .filt_narrow, .enc_run, .dec_run,
    .enc_irq, .dec_irq, .rate_factor4, .pcm_in_sel, .filt_src, .adm_dec_bit, .dec_out);
  host_master host (.ref_clk, .host_sclk, .host_cs_n, .host_cmd, .host_reply);

  // master clock runs throughout
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer(a, d, rd);
  endtask
  // a frame to a writable register also writes, so a read sends back the value it expects
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string m);
    host.xfer(a, e, rd);
    cmp(rd, e, m);
  endtask
  // run bit gates the three request sources
  function automatic logic irq_exp(input logic [3:0] c, input logic [2:0] e);
    return c[3] & |(c[2:0] & e);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    wt(90000);
    n_fail++;
    $display("mismatch t=%0t run too long", $time);
    tally_and_finish;
  end

  // main sequence
  initial begin
    void'($urandom(90923));
    rst = 1'b1;
    {rx_data_pin, filt_data, ext_tx_clk_pin, int_enc_clk, dec_clk, feedback_bit} = 6'h00;
    {decim_valid, transc_bit, transc_valid} = 3'h0;
    {enc_voice_chg, enc_pcm_tick, enc_adm_tick, dec_voice_chg, dec_pcm_tick, dec_adm_tick} = 6'h00;
    {burst_pcm, est_word, interp_word, decim_word} = 64'h0;
    wt(3);
    rst <= 1'b0;
    wt(4);
    cmp(16'({enc_run, dec_run, enc_irq, dec_irq, slicer_pwr, filt_narrow}), 16'h0000, "rst out");
    rdc(`CLK_SRC_ADDR, `CLK_SRC_RST, "clk rst");
    rdc(`IRQ_CTRL_ADDR, {8'h00, `IRQ_CTRL_RST}, "irq rst");
    rdc(`DEC_SETUP_ADDR, `DEC_SETUP_RST, "setup rst");
    // clock source, bypass, power and bandwidth, every select pattern
    for (int k = 0; k < 24; k++) begin
      cv = {10'h000, 2'(k), 4'($urandom)};
      wr(`CLK_SRC_ADDR, cv);
      {ext_tx_clk_pin, int_enc_clk, dec_clk, filt_data} <= 4'($urandom);
      rx_data_pin <= 1'($urandom);
      wt(5);
      ex = 16'(!cv[4] ? ext_tx_clk_pin : cv[5] ? dec_clk : int_enc_clk);
      cmp(16'(enc_bit_clk), ex, "enc clk");
      cmp(16'(slicer_in), 16'(cv[3] ? rx_data_pin : filt_data), "slicer in");
      cmp(16'(slicer_pwr), 16'(cv[2:1]), "pwr");
      cmp(16'(filt_narrow), 16'(cv[0]), "narrow");
    end
    rdc(`CLK_SRC_ADDR, cv, "clk rb");
    // request enables against random event pulses, corners first
    for (int k = 0; k < 16; k++) begin
      ic = (k == 0) ? 8'h88 : (k == 1) ? 8'h77 : 8'($urandom);
      wr(`IRQ_CTRL_ADDR, {8'h00, ic});
      wt(2);
      cmp(16'({enc_run, dec_run}), 16'({ic[7], ic[3]}), "run");
      pe = 6'h00;
      for (int c = 0; c < 40; c++) begin
        @(posedge ref_clk);
        ne = 6'($urandom);
        {enc_voice_chg, enc_pcm_tick, enc_adm_tick, dec_voice_chg, dec_pcm_tick, dec_adm_tick} <= ne;
        @(negedge ref_clk);
        ex = 16'({irq_exp(ic[7:4], pe[5:3]), irq_exp(ic[3:0], pe[2:0])});
        cmp(16'({enc_irq, dec_irq}), ex, "irq");
        pe = ne;
      end
      @(posedge ref_clk);
      {enc_voice_chg, enc_pcm_tick, enc_adm_tick, dec_voice_chg, dec_pcm_tick, dec_adm_tick} <= 6'h00;
    end
    rdc(`IRQ_CTRL_ADDR, {8'h00, ic}, "irq rb");
    wr(8'h55, 16'hffff);
    rdc(8'h55, 16'h0000, "unmapped");
    rdc(`IRQ_CTRL_ADDR, {8'h00, ic}, "irq kept");
    // status word: run bits, synced pins and power code
    ex = {10'h000, ic[7], ic[3], rx_data_pin, ext_tx_clk_pin, cv[2:1]};
    rdc(`STATUS_ADDR, ex, "status");
    // decoder routing over all input selects
    pin = 16'($urandom);
    fv = 16'($urandom);
    wr(`PCM_IN_ADDR, pin);
    wr(`DELTA_FEED_ADDR, fv);
    for (int k = 0; k < 16; k++) begin
      ps = 2'(k) | {k[3], 1'b0};
      sv = {1'($urandom), ps, 2'(k >> 2), 2'($urandom), 9'h000};
      wr(`DEC_SETUP_ADDR, sv);
      {rx_data_pin, feedback_bit} <= 2'($urandom);
      {est_word, interp_word} <= 32'($urandom);
      burst_pcm <= 16'($urandom);
      wt(5);
      fs = !ps[1] ? est_word : ps[0] ? pin : burst_pcm;
      case (sv[10:9])
        2'b00: ex = est_word;
        2'b01: ex = est_word + interp_word;
        2'b10: ex = fs;
        default: ex = interp_word;
      endcase
      b = k[3] ? feedback_bit : k[2] ? fv[15] : rx_data_pin;
      cmp(16'(rate_factor4), 16'(sv[15]), "rate");
      cmp(16'(pcm_in_sel), 16'(ps), "pcm sel");
      cmp(filt_src, fs, "filt src");
      cmp(16'(adm_dec_bit), 16'(b), "adm in");
      cmp(dec_out, ex, "dec out");
      rdc(`DEC_SETUP_ADDR, sv, "setup rb");
    end
    // host feed register played out bit by bit
    wr(`DEC_SETUP_ADDR, 16'h0800);
    for (int k = 0; k < 17; k++) begin
      wt(3);
      cmp(16'(adm_dec_bit), 16'(fv[15]), "feed");
      dec_adm_tick <= 1'b1;
      wt(1);
      dec_adm_tick <= 1'b0;
      fv = {fv[14:0], fv[15]};
    end
    // decimated word capture, later words not strobed must not land
    wr(`DEC_SETUP_ADDR, 16'h0000);
    dw = 16'($urandom);
    decim_word <= dw;
    decim_valid <= 1'b1;
    wt(1);
    decim_valid <= 1'b0;
    decim_word <= ~dw;
    wt(2);
    rdc(`PCM_OUT_ADDR, dw, "pcm out");
    // transcoded stream shifted into the result register
    wr(`DEC_SETUP_ADDR, 16'h5000);
    tr = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      b = 1'($urandom);
      transc_bit <= b;
      transc_valid <= 1'b1;
      wt(1);
      transc_valid <= 1'b0;
      wt(1);
      tr = {tr[14:0], b};
    end
    rdc(`DELTA_RESULT_ADDR, tr, "adm out");
    // reset in mid-run clears every control register and held output
    rst <= 1'b1;
    wt(3);
    rst <= 1'b0;
    wt(4);
    cmp(16'({enc_run, dec_run, pcm_in_sel, slicer_pwr}), 16'h0000, "rst2 out");
    rdc(`IRQ_CTRL_ADDR, {8'h00, `IRQ_CTRL_RST}, "irq rst2");
    rdc(`DEC_SETUP_ADDR, `DEC_SETUP_RST, "setup rst2");
    tally_and_finish;
  end
endmodule
`default_nettype wire
